// ==== rtl/wake_frame_detector.sv ====
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
// Contract
// - filter crc starts at 8-bit pattern offset
// - filter matches only when crc equals stored
// - frame wake only with wake_frame_enable set
// - only enabled filters with crc match count
// - broadcast match always wakes, ignoring broadcast_disable
// - address type qualifies frames passing receive filter
// - pattern_wake_enable suspends normal frame reception
// - pattern found sets status, powers up, wakes
// - pattern checked on own or broadcast frames
// - multicast frames with pattern also accepted
// - six ff sync bytes after address fields
// - sixteen back-to-back node address copies required
// - broken copy run restarts sync search
// - copies anywhere, but sync must precede them
// - 128-bit mask selects bytes from offset on
module wake_frame_detector #(
   parameter int NUM_FILT = wake_pkg::NUM_FILT_DEF
) (
   input  wire logic                i_sys_clk,
   input  wire logic                i_rstn,
   input  wire logic [9:0]          i_avs_address,
   input  wire logic                i_avs_read,
   input  wire logic                i_avs_write,
   input  wire logic [31:0]         i_avs_writedata,
   input  wire logic [3:0]          i_avs_byteenable,
   output logic [31:0]              o_avs_readdata,
   output logic                     o_avs_waitrequest,
   input  wire wake_pkg::rx_beat_s  i_rx,
   input  wire logic [47:0]         i_node_addr,
   output logic                     o_rx_suspend,
   output logic                     o_frame_wake,
   output logic                     o_power_up,
   output logic                     o_remote_wakeup,
   output logic                     o_irq
);
   import wake_pkg::*;

   if (NUM_FILT < 1 || NUM_FILT > 8) begin : g_bad_cfg
      $error("NUM_FILT must be 1 to 8");
   end

   // byte-lane mask from avalon byte enables
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // one 32-byte bank holds eight word registers
   function automatic logic in_bank(input logic [9:0] a, input logic [9:0] base);
      return a[9:5] == base[9:5];
   endfunction

   logic                       ack_q;
   logic                       wr_go;
   logic                       rd_go;
   logic [2:0]                 sel;
   logic                       sel_ok;
   logic                       cmd_sel;
   logic                       pofs_sel;
   logic                       crc_sel;
   logic                       mask_sel;
   logic [31:0]                rdata;
   logic [31:0]                wm;
   logic [31:0]                w1;
   logic [31:0]                wnew;
   logic [31:0]                wcs_rd;
   logic                       wcs_wr;
   logic                       pat_en_q;
   logic                       frame_en_q;
   logic                       uni_en_q;
   logic                       pat_rcvd_q;
   logic                       frm_rcvd_q;
   logic [1:0]                 irq_stat_q;
   logic [1:0]                 irq_en_q;
   logic [3:0]                 cmd_q [NUM_FILT];
   logic [7:0]                 pofs_q [NUM_FILT];
   logic [15:0]                exp_crc_q [NUM_FILT];
   logic [MASK_W-1:0]          mask_q [NUM_FILT];
   logic [IDX_W-1:0]           idx_q;
   logic [IDX_W-1:0]           idx_cur;
   logic [47:0]                da_q;
   logic                       broadcast_disable_q;
   logic                       mcast_q;
   logic                       own_q;
   logic                       pass_q;
   logic [NUM_FILT-1:0]        f_done;
   logic [NUM_FILT-1:0]        f_match;
   logic [NUM_FILT-1:0]        f_en;
   logic                       any_hit;
   logic                       frame_hit;
   logic                       pd_found;
   logic                       pat_hit;

   // one wait state: decode on the first cycle, answer on the second
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
   assign wr_go             = i_avs_write & ack_q;
   assign rd_go             = i_avs_read & ~ack_q;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) ack_q <= 1'b0;
      else ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
   end

   // address decode, filters past NUM_FILT are unmapped
   assign sel      = i_avs_address[4:2];
   assign sel_ok   = int'(sel) < NUM_FILT;
   assign cmd_sel  = in_bank(i_avs_address, CMD_BASE) && sel_ok;
   assign pofs_sel = in_bank(i_avs_address, POFS_BASE) && sel_ok;
   assign crc_sel  = in_bank(i_avs_address, CRC_BASE) && sel_ok;
   assign mask_sel = (i_avs_address[9:7] == MASK_BASE[9:7])
                     && (int'(i_avs_address[6:4]) < NUM_FILT);

   // control and status image
   always_comb begin
      wcs_rd               = WCS_RST;
      wcs_rd[WCS_PAT_EN]   = pat_en_q;
      wcs_rd[WCS_FRAME_EN] = frame_en_q;
      wcs_rd[WCS_PAT_RCVD] = pat_rcvd_q;
      wcs_rd[WCS_FRM_RCVD] = frm_rcvd_q;
      wcs_rd[WCS_UNI_EN]   = uni_en_q;
   end

   // read image; unmapped and write-only offsets read zero
   always_comb begin
      rdata = 32'h0000_0000;
      if (i_avs_address == WCS_OFS) begin
         rdata = wcs_rd;
      end else if (i_avs_address == IRQ_STAT_OFS) begin
         rdata[1:0] = irq_stat_q;
      end else if (i_avs_address == IRQ_EN_OFS) begin
         rdata[1:0] = irq_en_q;
      end else if (cmd_sel) begin
         rdata[3:0] = cmd_q[sel];
      end else if (pofs_sel) begin
         rdata[7:0] = pofs_q[sel];
      end else if (crc_sel) begin
         rdata[15:0] = exp_crc_q[sel];
      end else if (mask_sel) begin
         rdata = mask_q[i_avs_address[6:4]][{i_avs_address[3:2], 5'h00} +: 32];
      end
   end

   // byte-enabled writes merge into the current image
   assign wm     = lane_mask(i_avs_byteenable);
   assign w1     = i_avs_writedata & wm;
   assign wnew   = (rdata & ~wm) | w1;
   assign wcs_wr = wr_go && (i_avs_address == WCS_OFS);

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) o_avs_readdata <= 32'h0000_0000;
      else if (rd_go) o_avs_readdata <= rdata;
   end

   // software enables; host drops the pattern enable to resume reception
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pat_en_q   <= WCS_RST[WCS_PAT_EN];
         frame_en_q <= WCS_RST[WCS_FRAME_EN];
         uni_en_q   <= WCS_RST[WCS_UNI_EN];
      end else if (wcs_wr) begin
         pat_en_q   <= wnew[WCS_PAT_EN];
         frame_en_q <= wnew[WCS_FRAME_EN];
         uni_en_q   <= wnew[WCS_UNI_EN];
      end
   end

   // wake causes stay until written with one; a new event wins the clear
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pat_rcvd_q <= WCS_RST[WCS_PAT_RCVD];
         frm_rcvd_q <= WCS_RST[WCS_FRM_RCVD];
      end else begin
         pat_rcvd_q <= pat_hit | (pat_rcvd_q & ~(wcs_wr & w1[WCS_PAT_RCVD]));
         frm_rcvd_q <= frame_hit | (frm_rcvd_q & ~(wcs_wr & w1[WCS_FRM_RCVD]));
      end
   end

   // interrupt status, clear and enable
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_stat_q <= 2'h0;
         irq_en_q   <= 2'h0;
      end else begin
         irq_stat_q[IRQ_FRAME] <= frame_hit | (irq_stat_q[IRQ_FRAME]
                                  & ~(wr_go && i_avs_address == IRQ_CLR_OFS && w1[IRQ_FRAME]));
         irq_stat_q[IRQ_PAT]   <= pat_hit | (irq_stat_q[IRQ_PAT]
                                  & ~(wr_go && i_avs_address == IRQ_CLR_OFS && w1[IRQ_PAT]));
         if (wr_go && i_avs_address == IRQ_EN_OFS) irq_en_q <= wnew[1:0];
      end
   end

   assign o_irq = |(irq_stat_q & irq_en_q);

   // per-filter configuration; reserved command bit stays zero
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         for (int f = 0; f < NUM_FILT; f++) begin
            cmd_q[f]     <= 4'h0;
            pofs_q[f]    <= 8'h00;
            exp_crc_q[f] <= 16'h0000;
            mask_q[f]    <= '0;
         end
      end else if (wr_go) begin
         if (cmd_sel) cmd_q[sel] <= wnew[3:0] & CMD_WMASK;
         if (pofs_sel) pofs_q[sel] <= wnew[7:0];
         if (crc_sel) exp_crc_q[sel] <= wnew[15:0];
         if (mask_sel) mask_q[i_avs_address[6:4]][{i_avs_address[3:2], 5'h00} +: 32] <= wnew;
      end
   end

   // byte position within the frame, saturating on long frames
   assign idx_cur = i_rx.sof ? '0 : idx_q;

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) idx_q <= '0;
      else if (i_rx.vld) idx_q <= (&idx_cur) ? idx_cur : idx_cur + 1'b1;
   end

   // destination address captured from the first six bytes
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) da_q <= 48'h0000_0000_0000;
      else if (i_rx.vld && idx_cur < IDX_W'(6)) da_q <= {da_q[39:0], i_rx.data};
   end

   // frame class held from end of frame for the verdict cycle
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         broadcast_disable_q <= 1'b0;
         mcast_q <= 1'b0;
         own_q   <= 1'b0;
         pass_q  <= 1'b0;
      end else if (i_rx.vld && i_rx.eof) begin
         broadcast_disable_q <= &da_q;
         mcast_q <= da_q[40];
         own_q   <= da_q == i_node_addr;
         pass_q  <= i_rx.pass_filter;
      end
   end

   for (genvar f = 0; f < NUM_FILT; f++) begin : g_filt
      assign f_en[f] = cmd_q[f][CMD_EN];
      wake_crc_filter u_filt (
         .i_sys_clk  (i_sys_clk),
         .i_rstn     (i_rstn),
         .i_rx       (i_rx),
         .i_idx      (idx_cur),
         .i_offset   (pofs_q[f]),
         .i_mask     (mask_q[f]),
         .i_expected (exp_crc_q[f]),
         .o_done     (f_done[f]),
         .o_match    (f_match[f])
      );
   end

   // wake table; broadcast ignores broadcast_disable on purpose
   always_comb begin
      any_hit = 1'b0;
      for (int f = 0; f < NUM_FILT; f++) begin
         if (f_en[f] && f_match[f]) begin
            if (broadcast_disable_q) any_hit = 1'b1;
            if (!mcast_q && uni_en_q) any_hit = 1'b1;
            if (pass_q && (cmd_q[f][CMD_ANY]
                || (cmd_q[f][CMD_MCAST] ? (mcast_q && !broadcast_disable_q) : !mcast_q))) begin
               any_hit = 1'b1;
            end
         end
      end
   end

   assign frame_hit = f_done[0] & frame_en_q & any_hit;

   // normal reception held off while watching for the pattern
   assign o_rx_suspend = pat_en_q;

   wake_pattern_detect u_pat (
      .i_sys_clk   (i_sys_clk),
      .i_rstn      (i_rstn),
      .i_en        (pat_en_q),
      .i_rx        (i_rx),
      .i_idx       (idx_cur),
      .i_node_addr (i_node_addr),
      .o_found     (pd_found)
   );

   // own address, or group bit which covers broadcast and multicast
   assign pat_hit = pd_found & pat_en_q & (own_q | mcast_q);

   // wake pulses, registered so they line up with the status bits
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_frame_wake    <= 1'b0;
         o_power_up      <= 1'b0;
         o_remote_wakeup <= 1'b0;
      end else begin
         o_frame_wake    <= frame_hit;
         o_power_up      <= pat_hit;
         o_remote_wakeup <= pat_hit | frame_hit;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   a_wake_gated: assert property (o_frame_wake |-> $past(frame_en_q))
      else $error("frame wake while disabled");
   a_filter_enable: assert property (o_frame_wake |-> $past(|(f_en & f_match)))
      else $error("frame wake without enabled matching filter");
   a_broadcast_disable_wake: assert property (f_done[0] && frame_en_q && broadcast_disable_q
      && |(f_en & f_match) |=> o_frame_wake) else $error("broadcast match did not wake");
   a_unicast_wake: assert property (f_done[0] && frame_en_q && uni_en_q && !mcast_q
      && |(f_en & f_match) |=> o_frame_wake) else $error("unicast match did not wake");
   a_mcast_type: assert property (f_done[0] && frame_en_q && pass_q && mcast_q && !broadcast_disable_q
      && f_en[0] && f_match[0] && cmd_q[0][3:2] == 2'b10 |=> o_frame_wake)
      else $error("multicast type did not wake");
   a_suspend_rx: assert property ($rose(pat_en_q) |-> o_rx_suspend [*2] or !pat_en_q[*1])
      else $error("reception not suspended");
   a_pattern_status: assert property (pat_hit |=> pat_rcvd_q && o_power_up
      && o_remote_wakeup && irq_stat_q[IRQ_PAT]) else $error("pattern wake effects missing");
   a_pattern_addr: assert property (o_power_up |-> $past(own_q | mcast_q))
      else $error("pattern wake on foreign unicast");
   a_pattern_mcast: assert property (pd_found && pat_en_q && mcast_q |=> o_power_up)
      else $error("multicast pattern frame ignored");
   a_bus_answer: assert property (rd_go |=> !o_avs_waitrequest && o_avs_readdata == $past(rdata))
      else $error("read answer late or wrong");
   // bus pacing and status side effects
   a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("more than one wait state");
   a_frame_status: assert property (frame_hit |=> frm_rcvd_q && o_frame_wake
      && o_remote_wakeup && irq_stat_q[IRQ_FRAME]) else $error("frame wake effects missing");
   // a cause landing with its clear must survive, so only a quiet clear is checked
   a_status_clear: assert property (wcs_wr && w1[WCS_PAT_RCVD] && !pat_hit
      |=> !pat_rcvd_q) else $error("pattern status not cleared");

   c_frame_wake: cover property (o_frame_wake);
   c_pattern_wake: cover property (o_power_up);
   c_broadcast_disable_wake: cover property (f_done[0] && broadcast_disable_q ##1 o_frame_wake);
   c_irq: cover property (o_irq);
endmodule // wake_frame_detector

// ==== rtl/wake_pkg.sv ====
package wake_pkg;
   // frame and filter geometry
   localparam int NUM_FILT_DEF = 8;
   localparam int MASK_W       = 128;
   localparam int IDX_W        = 11;
   localparam int HDR_LEN      = 12;
   localparam int SYNC_LEN     = 6;
   localparam int ADDR_COPIES  = 16;
   localparam logic [7:0]  SYNC_BYTE = 8'hff;
   // crc-16 agreed with the driver that precomputes expected values
   localparam logic [15:0] CRC_POLY  = 16'h8005;
   localparam logic [15:0] CRC_INIT  = 16'hffff;
   // register byte offsets
   localparam logic [9:0] WCS_OFS      = 10'h000;
   localparam logic [9:0] IRQ_STAT_OFS = 10'h004;
   localparam logic [9:0] IRQ_CLR_OFS  = 10'h008;
   localparam logic [9:0] IRQ_EN_OFS   = 10'h00c;
   localparam logic [9:0] CMD_BASE     = 10'h040;
   localparam logic [9:0] POFS_BASE    = 10'h060;
   localparam logic [9:0] CRC_BASE     = 10'h080;
   localparam logic [9:0] MASK_BASE    = 10'h100;
   // wake_control_status fields and reset value
   localparam int WCS_PAT_EN   = 1;
   localparam int WCS_FRAME_EN = 2;
   localparam int WCS_PAT_RCVD = 5;
   localparam int WCS_FRM_RCVD = 6;
   localparam int WCS_UNI_EN   = 9;
   localparam logic [31:0] WCS_RST = 32'h0000_0000;
   // filter command fields
   localparam int CMD_EN    = 0;
   localparam int CMD_ANY   = 2;
   localparam int CMD_MCAST = 3;
   localparam logic [3:0] CMD_WMASK = 4'hd;
   // interrupt status bits
   localparam int IRQ_FRAME = 0;
   localparam int IRQ_PAT   = 1;

   typedef struct packed {
      logic       vld;
      logic       sof;
      logic       eof;
      logic       pass_filter;
      logic [7:0] data;
   } rx_beat_s;

   typedef enum logic [1:0] {
      PD_SEARCH = 2'b00,
      PD_ADDR   = 2'b01,
      PD_HIT    = 2'b11
   } pd_state_e;

   // msb-first crc-16 over one byte
   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int k = 7; k >= 0; k--) begin
         r = (r[15] ^ b[k]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
      end
      return r;
   endfunction
endpackage

// ==== rtl/wake_crc_filter.sv ====
`timescale 1ns/10ps
module wake_crc_filter (
   input  wire logic                         i_sys_clk,
   input  wire logic                         i_rstn,
   input  wire wake_pkg::rx_beat_s           i_rx,
   input  wire logic [wake_pkg::IDX_W-1:0]   i_idx,
   input  wire logic [7:0]                   i_offset,
   input  wire logic [wake_pkg::MASK_W-1:0]  i_mask,
   input  wire logic [15:0]                  i_expected,
   output logic                              o_done,
   output logic                              o_match
);
   import wake_pkg::*;

   logic [15:0]      crc_q;
   logic [15:0]      crc_base;
   logic [15:0]      crc_d;
   logic [IDX_W-1:0] rel;
   logic             take;

   // byte window starts at the pattern offset, mask picks bytes within it
   assign crc_base = i_rx.sof ? CRC_INIT : crc_q;
   assign rel      = i_idx - IDX_W'(i_offset);
   assign take     = i_rx.vld && (i_idx >= IDX_W'(i_offset))
                     && (rel < IDX_W'(MASK_W)) && i_mask[rel[6:0]];
   assign crc_d    = take ? crc16_byte(crc_base, i_rx.data) : crc_base;

   // running crc, restarted by each frame start
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) crc_q <= CRC_INIT;
      else if (i_rx.vld) crc_q <= crc_d;
   end

   // verdict one cycle after the last byte
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_done  <= 1'b0;
         o_match <= 1'b0;
      end else begin
         o_done  <= i_rx.vld & i_rx.eof;
         o_match <= i_rx.vld & i_rx.eof & (crc_d == i_expected);
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   a_crc_compare: assert property (o_match |-> crc_q == i_expected)
      else $error("filter match without crc equality");
   a_offset_skip: assert property (i_rx.vld && !i_rx.sof && (i_idx < IDX_W'(i_offset))
      |=> crc_q == $past(crc_q)) else $error("byte before offset changed crc");
   a_mask_skip: assert property (i_rx.vld && !i_rx.sof && !take |=> $stable(crc_q))
      else $error("unmasked byte changed crc");
endmodule // wake_crc_filter

// ==== rtl/wake_pattern_detect.sv ====
`timescale 1ns/10ps
module wake_pattern_detect (
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_rstn,
   input  wire logic                        i_en,
   input  wire wake_pkg::rx_beat_s          i_rx,
   input  wire logic [wake_pkg::IDX_W-1:0]  i_idx,
   input  wire logic [47:0]                 i_node_addr,
   output logic                             o_found
);
   import wake_pkg::*;

   pd_state_e   st_q;
   logic [2:0]  ff_cnt_q;
   logic [2:0]  pos_q;
   logic [4:0]  copies_q;
   logic [47:0] sh;
   logic [7:0]  want;
   logic        is_ff;
   logic        body;
   logic        last_copy;

   // expected address byte, first on the wire is the top byte
   assign sh        = i_node_addr << (6'(pos_q) * 6'd8);
   assign want      = sh[47:40];
   assign is_ff     = (i_rx.data == SYNC_BYTE);
   assign body      = i_rx.vld && !i_rx.sof && (i_idx >= IDX_W'(HDR_LEN));
   assign last_copy = (st_q == PD_ADDR) && body && (i_rx.data == want)
                      && (pos_q == 3'd5) && (copies_q == 5'(ADDR_COPIES - 1));

   // sync search, then address copies; a break falls back to search
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q     <= PD_SEARCH;
         ff_cnt_q <= 3'h0;
         pos_q    <= 3'h0;
         copies_q <= 5'h00;
      end else if (!i_en || (i_rx.vld && i_rx.sof)) begin
         st_q     <= PD_SEARCH;
         ff_cnt_q <= 3'h0;
         pos_q    <= 3'h0;
         copies_q <= 5'h00;
      end else if (body) begin
         case (st_q)
            PD_SEARCH: begin
               if (is_ff) begin
                  ff_cnt_q <= (ff_cnt_q == 3'(SYNC_LEN)) ? ff_cnt_q : ff_cnt_q + 3'h1;
               end else if (ff_cnt_q == 3'(SYNC_LEN) && i_rx.data == want) begin
                  st_q     <= PD_ADDR;
                  pos_q    <= 3'h1;
                  copies_q <= 5'h00;
                  ff_cnt_q <= 3'h0;
               end else begin
                  ff_cnt_q <= 3'h0;
               end
            end
            PD_ADDR: begin
               if (i_rx.data != want) begin
                  st_q     <= PD_SEARCH;
                  pos_q    <= 3'h0;
                  copies_q <= 5'h00;
                  ff_cnt_q <= is_ff ? 3'h1 : 3'h0;
               end else if (pos_q == 3'd5) begin
                  pos_q    <= 3'h0;
                  copies_q <= copies_q + 5'h01;
                  if (last_copy) st_q <= PD_HIT;
               end else begin
                  pos_q <= pos_q + 3'h1;
               end
            end
            PD_HIT: st_q <= PD_HIT;
            default: st_q <= PD_SEARCH;
         endcase
      end
   end

   // report at frame end, including a pattern completed by the last byte
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) o_found <= 1'b0;
      else o_found <= i_en & i_rx.vld & i_rx.eof & ((st_q == PD_HIT) | last_copy);
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   a_hit_after_16: assert property (st_q == PD_ADDR ##1 st_q == PD_HIT
      |-> $past(copies_q) == 5'(ADDR_COPIES - 1)) else $error("hit before 16 copies");
   a_break_resync: assert property (st_q == PD_ADDR && i_en && body && i_rx.data != want
      |=> st_q == PD_SEARCH) else $error("broken copy run not abandoned");
   a_sync_first: assert property (st_q != PD_ADDR ##1 st_q == PD_ADDR
      |-> $past(ff_cnt_q) == 3'(SYNC_LEN)) else $error("copies started without sync");
   c_hit: cover property (st_q == PD_HIT);
endmodule // wake_pattern_detect

// ==== tb/rx_source.sv ====
`timescale 1ns/10ps
// mac receive path stand-in: one byte a cycle, no back-pressure
module rx_source (
   input  wire logic          i_clk,
   output wake_pkg::rx_beat_s o_rx
);
   import wake_pkg::*;
   initial o_rx = '0;
   // idle data flips on each of the three idle cycles after a frame so a stale byte can never pose as a real one
   task automatic send(input logic [7:0] q[$], input logic pass);
      foreach (q[k]) begin
         @(posedge i_clk);
         o_rx <= '{1'b1, k == 0, k == q.size() - 1, pass, q[k]};
      end
      repeat (3) begin
         @(posedge i_clk);
         o_rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~o_rx.data};
      end
   endtask
endmodule // rx_source

// ==== tb/wake_frame_detector_bench.sv ====
`timescale 1ns/10ps
module wake_frame_detector_bench;
   import wake_pkg::*;
   localparam logic [47:0] NODE = 48'h02_a1_b2_c3_d4_e5;
   logic         i_sys_clk = 1'b0;
   logic         i_rstn = 1'b0;
   logic         rd_q = 1'b0;
   logic         wr_q = 1'b0;
   logic [9:0]   addr = '0;
   logic [31:0]  wdata = '0;
   logic [31:0]  rdata, rd;
   logic         wait_req, suspend, fwake, pwr_up, rwake, irq;
   rx_beat_s     rx;
   logic [7:0]   f[$];
   logic [3:0]   cmd;
   logic [127:0] msk;
   logic         pass, uni, fen, ex;
   int           errors = 0, check_count = 0, cyc = 0, ofs, b_fw, b_rw, b_pu;
   int           n_fw = 0, n_pu = 0, n_rw = 0;
   wake_frame_detector u_dut (.i_sys_clk, .i_rstn, .i_avs_address(addr), .i_avs_read(rd_q),
      .i_avs_write(wr_q), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_rx(rx), .i_node_addr(NODE),
      .o_rx_suspend(suspend), .o_frame_wake(fwake), .o_power_up(pwr_up),
      .o_remote_wakeup(rwake), .o_irq(irq));
   rx_source u_src (.i_clk(i_sys_clk), .o_rx(rx));
   always #2 i_sys_clk = ~i_sys_clk;
   // pulse tallies, plus a hang guard well past the expected run
   always @(posedge i_sys_clk) begin
      n_fw <= n_fw + fwake;
      n_pu <= n_pu + pwr_up;
      n_rw <= n_rw + rwake;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // an edge first, so a release and a new request never land in one step
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      addr <= a;
      wdata <= d;
      rd_q <= !wr;
      wr_q <= wr;
      do @(posedge i_sys_clk); while (wait_req !== 1'b0);
      rd = rdata;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
   endtask
   task automatic copies(input int n);
      repeat (n) for (int b = 5; b >= 0; b--) f.push_back(NODE[8 * b +: 8]);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // reference crc over the masked window, written independently of the design
   function automatic logic [15:0] crc_of();
      logic [15:0] c;
      c = CRC_INIT;
      for (int j = 0; j < 128 && ofs + j < f.size(); j++)
         if (msk[j]) for (int k = 7; k >= 0; k--)
            c = (c[15] ^ f[ofs + j][k]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
      return c;
   endfunction
   // wake table: broadcast, unicast with global enable, or qualified by address type
   function automatic logic wake_of();
      logic bc, uc;
      bc = &{f[0], f[1], f[2], f[3], f[4], f[5]};
      uc = !f[0][0];
      return cmd[0] & (bc | (uni & uc) | (pass & (cmd[2] | (cmd[3:2] == 2'b10 & !uc & !bc)
         | (cmd[3:2] == 2'b00 & uc))));
   endfunction
   initial begin
      void'($urandom(32'h655c5ac2));
      repeat (8) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      bus(0, WCS_OFS, 0);
      check(rd, WCS_RST);
      bus(1, IRQ_EN_OFS, 32'h3);
      for (int t = 0; t < 24; t++) begin
         cmd = 4'($urandom | (t % 4 != 3)) & CMD_WMASK;
         {pass, uni} = 2'($urandom);
         fen = (t % 5 != 4);
         ofs = $urandom_range(0, 40);
         msk = {$urandom, $urandom, $urandom, $urandom};
         f = {};
         repeat (64) f.push_back(8'($urandom));
         f[0][0] = (t % 3 != 0);
         if (t % 3 == 2) for (int k = 0; k < 6; k++) f[k] = 8'hff;
         ex = fen & wake_of() & (t % 6 != 5);
         bus(1, CMD_BASE, 32'(cmd));
         bus(1, POFS_BASE, 32'(ofs));
         bus(1, CRC_BASE, 32'(crc_of() ^ 16'(t % 6 == 5)));
         for (int w = 0; w < 4; w++) bus(1, MASK_BASE + 10'(4 * w), msk[32 * w +: 32]);
         bus(1, WCS_OFS, 32'({uni, 6'd0, fen, 2'd0}));
         b_fw = n_fw;
         b_rw = n_rw;
         u_src.send(f, pass);
         repeat (4) @(posedge i_sys_clk);
         check(n_fw - b_fw, ex);
         check(n_rw - b_rw, ex);
         check(irq, ex);
         bus(0, IRQ_STAT_OFS, 0);
         check(rd[IRQ_FRAME], ex);
         bus(1, IRQ_CLR_OFS, 32'h3);
      end
      $display("filter cases done");
      bus(1, WCS_OFS, 32'h2);
      @(posedge i_sys_clk);
      check(suspend, 1);
      for (int t = 0; t < 4; t++) begin
         f = {};
         if (t == 0) copies(1);
         else repeat (6) f.push_back(t == 3 ? 8'h06 : 8'h03);
         repeat (8) f.push_back(8'($urandom) & 8'h7f);
         repeat (6) f.push_back(SYNC_BYTE);
         copies(t == 0 ? 5 : 0);
         f.push_back(8'h00);
         repeat (6) f.push_back(SYNC_BYTE);
         copies(t == 1 ? 15 : 16);
         f.push_back(8'h00);
         b_pu = n_pu;
         u_src.send(f, 1'b1);
         repeat (4) @(posedge i_sys_clk);
         check(n_pu - b_pu, t == 0 || t == 2);
      end
      bus(0, WCS_OFS, 0);
      check(rd[WCS_PAT_RCVD], 1);
      bus(1, WCS_OFS, 32'h60);
      bus(0, WCS_OFS, 0);
      check(rd, 0);
      check(suspend, 0);
      bus(0, 10'h3f0, 0);
      check(rd, 0);
      $display("pattern cases done");
      complete_run();
   end
endmodule // wake_frame_detector_bench
